// *** core/rtwk_timer.v ***
// Reload timer with wake-up timer control, Wishbone classic slave
// Operation
// - Stop-on-receive set: halt once four received bits arrive; clear: never
// - Stop-on-receive ignored in either oscillator trimming start mode
// - Start select 00 no auto start; 01 starts at end of transmission
// - Start select 10/11 trimming, start and stop on rising edges
// - Auto-restart set: reload and keep counting at zero
// - Auto-restart clear: count to zero and stay stopped
// - Every underflow sets the underflow interrupt flag, except in start select 10
// - Clock select 00 carrier tick, 01 divided tick
// - Clock select 10/11 count sibling timer underflows
// - Start event loads 16-bit value from both reload bytes
// - Reload writes do not disturb a running countdown
// - Current count readable as high and low bytes
// - Wake-up timer wakes system when interval elapses
// - Wake-up timer can launch low-power card detection
// - Wake control layout: run, strobe, trim, detect, reload, wake, clock
// - Running bit written only when strobe written as one; one-shot wake underflow clears it
// - Wake clock: oscillator undivided, /8, /16 or /32
// - Wake underflow sets its flag; reload or stop at zero
// - Auto-wake set: leave power-down on each wake underflow
//
// Bus behaviour
// Single-cycle ack, one clock after the request edge
// Writes take effect at the request edge
// Unmapped reads return zero, unmapped writes dropped
// Lane 0 must be enabled for a write to land
// Main timer behaviour
// Tick inputs are single-cycle pulses on this clock
// Start events win over halt and ticks in one cycle
// Trimming start: first rising edge starts, second stops
// Halt happens with the fourth received bit itself
// Underflow pulse suppressed in plain trimming mode
// Count bytes are not latched as a pair
// Software keeps off the count bytes during reception
// Wake timer behaviour
// Wake ticks come from the synchronised oscillator
// Strobe write with run bit set loads the wake interval
// Wake underflow raises wake, detect and trim by enable
// A control write in an underflow cycle takes priority
// Wake interval is a parameter, not a register
// Status register
// Bit 0 underflow, bit 1 running, bit 2 wake underflow
// Write one to clear; a new event in that cycle wins
`timescale 1ns/1ps
`default_nettype none
`include "rtwk_map.vh"

module rtwk_timer #(
	parameter WAKE_RELOAD = 16'hFFFF
) (
	// System
	input  wire       clk_i,
	input  wire       rst_i,
	// Wishbone slave
	input  wire       cyc_i,
	input  wire       stb_i,
	input  wire       we_i,
	input  wire [5:0] adr_i,
	input  wire [0:0] sel_i,
	input  wire [7:0] dat_i,
	output reg  [7:0] dat_o,
	output reg        ack_o,
	// Tick and event inputs, same clock
	input  wire       carrier_tick_i,
	input  wire       div_tick_i,
	input  wire       sib0_underflow_i,
	input  wire       sib1_underflow_i,
	input  wire       tx_end_i,
	input  wire       rx_bit_i,
	input  wire       rx_active_i,
	// Oscillator, from outside the domain
	input  wire       low_freq_osc_clk_i,
	input  wire       trim_edge_i,
	// Outputs
	output reg        underflow_o,
	output reg        wake_o,
	output reg        card_detect_start_o,
	output reg        osc_trim_start_o
);

	reg  [7:0]  ctrl_q;
	reg  [7:0]  rld_hi_q;
	reg  [7:0]  rld_lo_q;
	reg  [15:0] cnt_q;
	reg         run_q;
	reg         irq_q;
	reg  [2:0]  rx_bits_q;
	reg  [7:0]  wctrl_q;
	reg  [15:0] wcnt_q;
	reg         wirq_q;
	reg  [4:0]  wdiv_q;
	reg  [1:0]  low_freq_osc_sync_q;
	reg  [1:0]  trim_sync_q;
	reg         low_freq_osc_prev_q;
	reg         trim_prev_q;

	wire        wr_stb;
	wire        cnt_tick;
	wire        trim_mode;
	wire        trim_rise;
	wire        low_freq_osc_rise;
	wire [7:0]  wk_wdata;
	wire        wake_tick;
	wire [1:0]  start_sel;
	wire [1:0]  clk_sel;
	wire [15:0] reload_value;

	// Write strobe, byte lane 0 only
	// Qualified by !ack so a held request writes once
	// Shared by every register write decode
	// Address compare against one register offset
	function is_wr;
		input [5:0] a;
		input [5:0] off;
		begin
			is_wr = wr_stb && (a == off);
		end
	endfunction

	assign wr_stb       = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
	assign start_sel    = ctrl_q[`RTWK_CTL_START_HI:`RTWK_CTL_START_LO];
	assign clk_sel      = ctrl_q[`RTWK_CTL_CLK_HI:`RTWK_CTL_CLK_LO];
	assign reload_value = {rld_hi_q, rld_lo_q};
	assign trim_mode    = start_sel[1];
	assign trim_rise    = trim_sync_q[1] && !trim_prev_q;
	assign low_freq_osc_rise = low_freq_osc_sync_q[1] && !low_freq_osc_prev_q;
	assign wk_wdata     = dat_i & `RTWK_WK_WMASK;

	// Tick source select
	assign cnt_tick = (clk_sel == `RTWK_CLK_CARRIER) ? carrier_tick_i :
		(clk_sel == `RTWK_CLK_DIV) ? div_tick_i :
		(clk_sel == `RTWK_CLK_SIB0) ? sib0_underflow_i : sib1_underflow_i;

	// Bus acknowledge, one cycle
	// Registered, so the answer comes one clock late
	// Drops by itself after one cycle
	// Back-to-back requests need an idle cycle between
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
		end
	end

	// Read mux, registered
	// Loaded only at the request edge
	// Holds between accesses
	// Strobe bit of wake control always reads zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 8'h00;
		end else if (cyc_i && stb_i && !ack_o) begin
			case (adr_i)
				`RTWK_OFF_CTRL:      dat_o <= ctrl_q;
				`RTWK_OFF_RLD_HI:    dat_o <= rld_hi_q;
				`RTWK_OFF_RLD_LO:    dat_o <= rld_lo_q;
				`RTWK_OFF_CNT_HI:    dat_o <= cnt_q[15:8];
				`RTWK_OFF_CNT_LO:    dat_o <= cnt_q[7:0];
				`RTWK_OFF_WAKE_CTRL: dat_o <= wctrl_q & ~(8'h01 << `RTWK_WK_STROBE);
				`RTWK_OFF_STATUS:    dat_o <= {5'h00, wirq_q, run_q, irq_q};
				default:             dat_o <= 8'h00;
			endcase
		end
	end

	// Control and reload registers
	// Reserved control bits masked on write
	// Reload bytes only copied at a start event or auto-reload
	// No effect on a countdown in progress
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= 8'h00;
			rld_hi_q <= 8'h00;
			rld_lo_q <= 8'h00;
		end else begin
			if (is_wr(adr_i, `RTWK_OFF_CTRL))
				ctrl_q <= dat_i & `RTWK_CTL_WMASK;
			if (is_wr(adr_i, `RTWK_OFF_RLD_HI))
				rld_hi_q <= dat_i;
			if (is_wr(adr_i, `RTWK_OFF_RLD_LO))
				rld_lo_q <= dat_i;
		end
	end

	// Oscillator and trim pin synchronisers
	// Two flops each, only the second is read
	// Previous-value flops give rising edge detection
	// Reset low matches the idle pin level
	// Pin pulses must last at least two clocks
	always @(posedge clk_i) begin
		if (rst_i) begin
			low_freq_osc_sync_q <= 2'h0;
			trim_sync_q         <= 2'h0;
			low_freq_osc_prev_q <= 1'b0;
			trim_prev_q         <= 1'b0;
		end else begin
			low_freq_osc_sync_q <= {low_freq_osc_sync_q[0], low_freq_osc_clk_i};
			trim_sync_q         <= {trim_sync_q[0], trim_edge_i};
			low_freq_osc_prev_q <= low_freq_osc_sync_q[1];
			trim_prev_q <= trim_sync_q[1];
		end
	end

	// Received bit counter for stop-on-receive
	// Cleared whenever reception is idle
	// Saturates at four bits per frame
	// Halt fires on the bit that makes four
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_bits_q <= 3'h0;
		end else if (!rx_active_i) begin
			rx_bits_q <= 3'h0;
		end else if (rx_bit_i && rx_bits_q != `RTWK_RX_NIBBLE) begin
			rx_bits_q <= rx_bits_q + 3'h1;
		end
	end

	// Main countdown
	// Priority: trim edge, transmit end, halt, tick
	// Trim edge toggles running in trimming modes
	// Transmit end starts only in start select 01
	// Halt ignored while a trimming mode is chosen
	// Tick at zero gives underflow next cycle
	// Auto-restart reloads, otherwise the timer stops
	// Count frozen whenever the timer is stopped
	// Plain trimming mode never pulses underflow
	// Reload value sampled only at start and reload
	// Underflow output is a one-cycle registered pulse
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q       <= 16'h0000;
			run_q       <= 1'b0;
			underflow_o <= 1'b0;
		end else begin
			underflow_o <= 1'b0;
			if (trim_mode && trim_rise) begin
				if (run_q) begin
					run_q <= 1'b0;
				end else begin
					run_q <= 1'b1;
					cnt_q <= reload_value;
				end
			end else if (start_sel == `RTWK_START_TXEND && tx_end_i) begin
				run_q <= 1'b1;
				cnt_q <= reload_value;
			end else if (!trim_mode && ctrl_q[`RTWK_CTL_HALT_RX] && run_q
				&& rx_bit_i && rx_bits_q == (`RTWK_RX_NIBBLE - 3'h1)) begin
				run_q <= 1'b0;
			end else if (run_q && cnt_tick) begin
				if (cnt_q == 16'h0000) begin
					if (start_sel != `RTWK_START_TRIM) begin
						underflow_o <= 1'b1;
					end
					if (ctrl_q[`RTWK_CTL_AUTO_RLD]) begin
						cnt_q <= reload_value;
					end else begin
						run_q <= 1'b0;
					end
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end

	// Underflow flag, set wins over clear by writing one
	// Set from the registered underflow pulse
	// Cleared by writing one to status bit 0
	// Sticky until software clears it
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else if (underflow_o) begin
			irq_q <= 1'b1;
		end else if (is_wr(adr_i, `RTWK_OFF_STATUS) && dat_i[`RTWK_ST_IRQ]) begin
			irq_q <= 1'b0;
		end
	end

	// Wake prescaler decode, one hit per selected division
	function wake_div_hit;
		input [1:0] sel;
		input [4:0] div;
		begin
			case (sel)
				`RTWK_WCLK_DIV1:  wake_div_hit = 1'b1;
				`RTWK_WCLK_DIV8:  wake_div_hit = ((div & `RTWK_WDIV_8) == `RTWK_WDIV_8);
				`RTWK_WCLK_DIV16: wake_div_hit = ((div & `RTWK_WDIV_16) == `RTWK_WDIV_16);
				`RTWK_WCLK_DIV32: wake_div_hit = (div == `RTWK_WDIV_32);
				default:          wake_div_hit = 1'b0;
			endcase
		end
	endfunction

	// Wake clock prescaler
	// Free-running divider on oscillator rising edges
	// Phase not reset by control writes
	assign wake_tick = low_freq_osc_rise &&
		wake_div_hit(wctrl_q[`RTWK_WK_CLK_HI:`RTWK_WK_CLK_LO], wdiv_q);

	always @(posedge clk_i) begin
		if (rst_i) begin
			wdiv_q <= 5'h00;
		end else if (low_freq_osc_rise) begin
			wdiv_q <= wdiv_q + 5'h01;
		end
	end

	// Wake-up timer control and countdown
	// Running bit only written by software together with the strobe bit
	// Strobe with running set loads the interval
	// Strobe with running clear stops the timer
	// Underflow pulses gated by their enable bits
	// Auto-restart reloads, otherwise running clears
	// Control writes beat an underflow in one cycle
	// Wake pulse leaves power-down outside this block
	// Detect pulse launches the card detection sequence
	// Trim pulse launches the oscillator trimming sequence
	always @(posedge clk_i) begin
		if (rst_i) begin
			wctrl_q             <= 8'h00;
			wcnt_q              <= 16'h0000;
			wake_o              <= 1'b0;
			card_detect_start_o <= 1'b0;
			osc_trim_start_o    <= 1'b0;
		end else begin
			wake_o              <= 1'b0;
			card_detect_start_o <= 1'b0;
			osc_trim_start_o    <= 1'b0;
			if (is_wr(adr_i, `RTWK_OFF_WAKE_CTRL)) begin
				wctrl_q[`RTWK_WK_TRIM:`RTWK_WK_CLK_LO] <=
					wk_wdata[`RTWK_WK_TRIM:`RTWK_WK_CLK_LO];
				if (dat_i[`RTWK_WK_STROBE]) begin
					wctrl_q[`RTWK_WK_RUNNING] <= dat_i[`RTWK_WK_RUNNING];
					wcnt_q <= WAKE_RELOAD;
				end
			end else if (wctrl_q[`RTWK_WK_RUNNING] && wake_tick) begin
				if (wcnt_q == 16'h0000) begin
					wake_o              <= wctrl_q[`RTWK_WK_WAKE];
					card_detect_start_o <= wctrl_q[`RTWK_WK_DETECT];
					osc_trim_start_o    <= wctrl_q[`RTWK_WK_TRIM];
					if (wctrl_q[`RTWK_WK_AUTO_RLD]) begin
						wcnt_q <= WAKE_RELOAD;
					end else begin
						wctrl_q[`RTWK_WK_RUNNING] <= 1'b0;
					end
				end else begin
					wcnt_q <= wcnt_q - 16'h0001;
				end
			end
		end
	end

	// Wake underflow flag
	// Same condition as the countdown underflow branch
	// Cleared by writing one to status bit 2
	// Set wins over a clear in the same cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			wirq_q <= 1'b0;
		end else if (wctrl_q[`RTWK_WK_RUNNING] && wake_tick && wcnt_q == 16'h0000
			&& !is_wr(adr_i, `RTWK_OFF_WAKE_CTRL)) begin
			wirq_q <= 1'b1;
		end else if (is_wr(adr_i, `RTWK_OFF_STATUS) && dat_i[`RTWK_ST_WIRQ]) begin
			wirq_q <= 1'b0;
		end
	end

endmodule // rtwk_timer
`default_nettype wire

// *** core/rtwk_map.vh ***
// Register offsets, field positions and encodings of the reload timer block
`ifndef RTWK_MAP_VH
`define RTWK_MAP_VH
`define RTWK_OFF_CTRL      6'h1E
`define RTWK_OFF_RLD_HI    6'h1F
`define RTWK_OFF_RLD_LO    6'h20
`define RTWK_OFF_CNT_HI    6'h21
`define RTWK_OFF_CNT_LO    6'h22
`define RTWK_OFF_WAKE_CTRL 6'h23
`define RTWK_OFF_STATUS    6'h28
`define RTWK_CTL_HALT_RX   7
`define RTWK_CTL_START_HI  5
`define RTWK_CTL_START_LO  4
`define RTWK_CTL_AUTO_RLD  3
`define RTWK_CTL_CLK_HI    1
`define RTWK_CTL_CLK_LO    0
`define RTWK_CTL_WMASK     8'hBB
`define RTWK_WK_RUNNING    7
`define RTWK_WK_STROBE     6
`define RTWK_WK_WMASK      8'h3F
`define RTWK_WK_TRIM       5
`define RTWK_WK_DETECT     4
`define RTWK_WK_AUTO_RLD   3
`define RTWK_WK_WAKE       2
`define RTWK_WK_CLK_HI     1
`define RTWK_WK_CLK_LO     0
`define RTWK_WCLK_DIV1     2'h0
`define RTWK_WCLK_DIV8     2'h1
`define RTWK_WCLK_DIV16    2'h2
`define RTWK_WCLK_DIV32    2'h3
`define RTWK_ST_IRQ        0
`define RTWK_ST_RUN        1
`define RTWK_ST_WIRQ       2
`define RTWK_START_NONE    2'h0
`define RTWK_START_TXEND   2'h1
`define RTWK_START_TRIM    2'h2
`define RTWK_START_TRIM_UF 2'h3
`define RTWK_CLK_CARRIER   2'h0
`define RTWK_CLK_DIV       2'h1
`define RTWK_CLK_SIB0      2'h2
`define RTWK_CLK_SIB1      2'h3
`define RTWK_RX_NIBBLE     3'h4
`define RTWK_WDIV_8        5'h07
`define RTWK_WDIV_16       5'h0F
`define RTWK_WDIV_32       5'h1F
`endif

// *** dv/rtwk_timer_monitor.sv ***
// Bus handshake and wake output checks for the reload timer
`timescale 1ns/1ps
`default_nettype none
module rtwk_monitor (
	// System and bus
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       we_i,
	input wire logic [5:0] adr_i,
	input wire logic [7:0] dat_o,
	input wire logic       ack_o,
	// Wake outputs
	input wire logic       wake_o,
	input wire logic       card_detect_start_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request taken and its one-cycle answer
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ans;
		ack_o ##1 !ack_o;
	endsequence
	ack_once_a: assert property (s_req |=> s_ans) else $error("ack not one pulse");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
	ack_idle_a: assert property (!cyc_i |=> !ack_o) else $error("ack while idle");
	unmap_zero_a: assert property (ack_o && !we_i && adr_i == 6'h3F |-> dat_o == 8'h00)
		else $error("unmapped read not zero");
	rd_hold_a: assert property (!cyc_i && !ack_o |=> $stable(dat_o))
		else $error("read data moved");
	wake_once_a: assert property (wake_o |=> !wake_o) else $error("wake too long");
	detect_once_a: assert property (card_detect_start_o |=> !card_detect_start_o)
		else $error("detect too long");
	rst_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !wake_o) else $error("busy at reset");
endmodule // rtwk_monitor
bind rtwk_timer rtwk_monitor i_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
	.ack_o, .wake_o, .card_detect_start_o);
`default_nettype wire

// *** dv/rtwk_timer_tb.sv ***
// Register level bench for the reload timer
`timescale 1ns/1ps
`default_nettype none
module rtwk_timer_tb;
	logic       clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
	logic       rxa = 0, osc = 0, trim = 0, ack, wk, cd, uf, ot;
	logic [5:0] adr = 0, ev = 0, m;
	logic [7:0] wd = 0, dat, rd;
	int         errors = 0, cmp_count = 0, n = 0, ufn = 0, wkn = 0, cdn = 0, otn = 0;
	// Device with a short wake interval
	rtwk_timer #(.WAKE_RELOAD(16'h0003)) i_dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(1'b1), .dat_i(wd), .dat_o(dat), .ack_o(ack),
		.carrier_tick_i(ev[0]), .div_tick_i(ev[1]), .sib0_underflow_i(ev[2]),
		.sib1_underflow_i(ev[3]), .tx_end_i(ev[4]), .rx_bit_i(ev[5]), .rx_active_i(rxa),
		.low_freq_osc_clk_i(osc), .trim_edge_i(trim), .underflow_o(uf), .wake_o(wk),
		.card_detect_start_o(cd), .osc_trim_start_o(ot));
	// System clock and unrelated oscillator
	always #4 clk = ~clk;
	always #52 osc = ~osc;
	// Pulse counters and run timeout
	always @(posedge clk) begin
		n <= n + 1;
		ufn <= ufn + uf;
		wkn <= wkn + wk;
		cdn <= cdn + cd;
		otn <= otn + ot;
		if (n == 20000) begin
			errors = errors + 1;
			final_report;
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic single cycle, released after the ack edge
	task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
		wb(0, a, 8'h00);
		chk(nm, rd, e);
	endtask
	task automatic cnt(input logic [15:0] e);
		rdc("count_hi", 6'h21, e[15:8]);
		rdc("count_lo", 6'h22, e[7:0]);
	endtask
	// Event pulses, one idle cycle after each
	task automatic pulse(input logic [5:0] p, input int k);
		repeat (k) begin
			ev <= p;
			@(posedge clk);
			ev <= 0;
			@(posedge clk);
		end
	endtask
	// Trim pin high long enough to pass its synchroniser
	task automatic trim_pulse;
		trim <= 1;
		repeat (6) @(posedge clk);
		trim <= 0;
		repeat (6) @(posedge clk);
	endtask
	task automatic final_report;
		$display("Compared %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		wb(1, 6'h1F, 8'h00);
		wb(1, 6'h20, 8'h05);
		rdc("reload_lo", 6'h20, 8'h05);
		wb(1, 6'h3F, 8'hA5);
		rdc("unmapped", 6'h3F, 8'h00);
		// One-shot countdown, reload rewritten mid-run
		wb(1, 6'h1E, 8'h10);
		pulse(6'h10, 1);
		cnt(16'h0005);
		wb(1, 6'h20, 8'h09);
		pulse(6'h01, 2);
		cnt(16'h0003);
		pulse(6'h01, 6);
		cnt(16'h0000);
		chk("underflows", 8'(ufn), 8'h01);
		wb(1, 6'h1E, 8'h00);
		pulse(6'h11, 2);
		cnt(16'h0000);
		// Auto reload, then each clock source
		wb(1, 6'h1E, 8'h18);
		pulse(6'h10, 1);
		pulse(6'h01, 10);
		cnt(16'h0009);
		chk("underflows", 8'(ufn), 8'h02);
		for (int c = 0; c < 4; c++) begin
			m = 6'h01 << c;
			wb(1, 6'h1E, 8'h18 | 8'(c));
			pulse(6'h10, 1);
			pulse(m ^ 6'h0F, 2);
			pulse(m, 2);
			cnt(16'h0007);
		end
		// Halt on received bits, set and clear
		for (int h = 0; h < 2; h++) begin
			wb(1, 6'h1E, h ? 8'h98 : 8'h18);
			pulse(6'h10, 1);
			pulse(6'h01, 1);
			rxa <= 1;
			pulse(6'h20, 4);
			rxa <= 0;
			pulse(6'h01, 2);
			cnt(h ? 16'h0008 : 16'h0006);
		end
		// Trimming mode ignores the halt bit, second edge stops
		wb(1, 6'h1E, 8'hA8);
		trim_pulse;
		rxa <= 1;
		pulse(6'h20, 4);
		rxa <= 0;
		pulse(6'h01, 2);
		cnt(16'h0007);
		trim_pulse;
		pulse(6'h01, 2);
		cnt(16'h0007);
		// Trimming to zero: underflow pulse only in the second trim mode
		wb(1, 6'h1E, 8'h20);
		trim_pulse;
		pulse(6'h01, 10);
		cnt(16'h0000);
		chk("underflows", 8'(ufn), 8'h02);
		wb(1, 6'h1E, 8'h30);
		trim_pulse;
		pulse(6'h01, 10);
		cnt(16'h0000);
		chk("underflows", 8'(ufn), 8'h03);
		// Wake timer run bit needs the strobe
		wb(1, 6'h23, 8'hDC);
		rdc("wake_ctl", 6'h23, 8'h9C);
		for (int i = 0; i < 500 && wkn == 0; i++) @(posedge clk);
		chk("wake", 8'(wkn > 0), 8'h01);
		chk("detect", 8'(cdn > 0), 8'h01);
		wb(1, 6'h23, 8'h0C);
		rdc("wake_ctl", 6'h23, 8'h8C);
		wb(1, 6'h23, 8'h40);
		rdc("wake_ctl", 6'h23, 8'h00);
		// One-shot wake run with only the trim launch enabled
		wb(1, 6'h23, 8'hE0);
		for (int i = 0; i < 500 && otn == 0; i++) @(posedge clk);
		chk("trim_start", 8'(otn), 8'h01);
		rdc("wake_ctl", 6'h23, 8'h20);
		rdc("status", 6'h28, 8'h05);
		wb(1, 6'h28, 8'h05);
		rdc("status", 6'h28, 8'h00);
		final_report;
	end
endmodule // rtwk_timer_tb
`default_nettype wire
